// ===== core/pin_control.sv
// Reset filter, NMI and power-down gating, and ninth-port pin control
//
// Chosen here: the address map and the strobed register port.
`timescale 1ns/1ps

// Functional notes
// - Low reset pin with clock running resets
// - Filter rejects <10 ns, passes >100 ns
// - NMI falling edge requests trap vector
// - Power-down with NMI low enters power-down
// - Power-down with NMI high is ignored
// - Six pins, each input or output
// - Output pins push-pull or open-drain
// - Port threshold standard or special
// - Pins 0-5 serve capcom channels 16-21
// - Fast interrupts 7/6 routed alternate A/B
module pin_control (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // Reset and NMI pins
    input wire logic reset_input_pin_n,
    input wire logic nmi_pin_n,
    // CPU side
    input wire logic power_down_instruction,
    output logic sys_reset_req,
    output logic nmi_trap_req,
    output logic power_down_mode,
    output logic power_down_ignored,
    // Ninth port pins
    input wire logic [5:0] ninth_port_in,
    output logic [5:0] ninth_port_out,
    output logic [5:0] ninth_port_oe,
    output logic special_threshold,
    // Second capture/compare unit, channels 16 to 21
    input wire logic [5:0] capcom_compare_out,
    output logic [5:0] capcom_capture_in,
    // Fast external interrupts
    output logic fast_ext_irq_seven_input,
    output logic fast_ext_irq_six_input,
    // Memory bus control
    output logic [3:0] flash_waitstate_field
);
    typedef struct packed {
        logic [5:0] port_data;
        logic [5:0] port_dir;
        logic [5:0] port_od;
        logic [5:0] port_alt;
        logic [2:0] port_ctrl;
        logic [3:0] waitstates;
        logic [2:0] low_cnt;
        logic rst_req;
        logic nmi_prev;
        logic nmi_trap;
        logic pd_mode;
        logic pd_ign;
        logic pd_ign_seen;
        logic [5:0] pin_out;
        logic [5:0] pin_oe;
        logic [5:0] cap_in;
        logic irq7;
        logic irq6;
        logic [15:0] rdata;
    } ctl_state_t;

    ctl_state_t st_r;
    ctl_state_t st_nxt;

    logic rst_pin_s;
    logic nmi_pin_s;
    logic [5:0] port_pin_s;

    // Decodes a register write or read at one offset
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
        hit = (addr == ofs);
    endfunction

    // Pins arrive asynchronously; nothing looks at them before two flops
    pin_sync #(
        .W(8),
        .INIT(8'hFF)
    ) u_sync (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .async_in({ninth_port_in, nmi_pin_n, reset_input_pin_n}),
        .sync_out({port_pin_s, nmi_pin_s, rst_pin_s})
    );

    logic [5:0] drive_val;
    logic sel7;
    logic sel6;

    always_comb
    begin
        st_nxt = st_r;
        sel7 = st_r.port_ctrl[pinctl_pkg::CTRL_SEL7_BIT];
        sel6 = st_r.port_ctrl[pinctl_pkg::CTRL_SEL6_BIT];

        // Reset filter: a low must persist over consecutive samples; one
        // sample is the most a short spike can corrupt
        if (!rst_pin_s)
        begin
            if (st_r.low_cnt != 3'(pinctl_pkg::RST_FILT_CYC))
            begin
                st_nxt.low_cnt = st_r.low_cnt + 3'h1;
            end
        end
        else
        begin
            st_nxt.low_cnt = 3'h0;
        end
        st_nxt.rst_req = !rst_pin_s && (st_r.low_cnt >= 3'(pinctl_pkg::RST_FILT_CYC - 1));

        // NMI falling edge gives a one-cycle trap request
        st_nxt.nmi_prev = nmi_pin_s;
        st_nxt.nmi_trap = st_r.nmi_prev && !nmi_pin_s && !st_r.rst_req;

        // Power-down gating by the synchronised NMI level
        st_nxt.pd_ign = 1'b0;
        if (power_down_instruction && !st_r.pd_mode)
        begin
            if (!nmi_pin_s)
            begin
                st_nxt.pd_mode = 1'b1;
            end
            else
            begin
                st_nxt.pd_ign = 1'b1;
                st_nxt.pd_ign_seen = 1'b1;
            end
        end
        // Only a reset leaves power-down
        if (st_r.rst_req)
        begin
            st_nxt.pd_mode = 1'b0;
        end

        // Register writes
        if (reg_wr)
        begin
            if (hit(reg_addr, pinctl_pkg::OFS_PORT_DATA))
            begin
                st_nxt.port_data = reg_wdata[5:0];
            end
            if (hit(reg_addr, pinctl_pkg::OFS_PORT_DIR))
            begin
                st_nxt.port_dir = reg_wdata[5:0];
            end
            if (hit(reg_addr, pinctl_pkg::OFS_PORT_OD))
            begin
                st_nxt.port_od = reg_wdata[5:0];
            end
            if (hit(reg_addr, pinctl_pkg::OFS_PORT_ALT))
            begin
                st_nxt.port_alt = reg_wdata[5:0];
            end
            if (hit(reg_addr, pinctl_pkg::OFS_PORT_CTRL))
            begin
                st_nxt.port_ctrl = reg_wdata[2:0];
            end
            if (hit(reg_addr, pinctl_pkg::OFS_MEM_BUS_CTRL))
            begin
                st_nxt.waitstates = reg_wdata[pinctl_pkg::WS_LSB +: 4];
            end
        end

        // Reading status clears the sticky ignored flag; a new event wins
        if (reg_rd && hit(reg_addr, pinctl_pkg::OFS_STATUS) && !st_nxt.pd_ign)
        begin
            st_nxt.pd_ign_seen = 1'b0;
        end

        // Register reads: data stands in the next cycle only
        st_nxt.rdata = 16'h0000;
        if (reg_rd)
        begin
            case (reg_addr)
                pinctl_pkg::OFS_PORT_DATA: st_nxt.rdata = {10'h000, st_r.port_data};
                pinctl_pkg::OFS_PORT_DIR: st_nxt.rdata = {10'h000, st_r.port_dir};
                pinctl_pkg::OFS_PORT_OD: st_nxt.rdata = {10'h000, st_r.port_od};
                pinctl_pkg::OFS_PORT_ALT: st_nxt.rdata = {10'h000, st_r.port_alt};
                pinctl_pkg::OFS_PORT_CTRL: st_nxt.rdata = {13'h0000, st_r.port_ctrl};
                pinctl_pkg::OFS_PORT_PINS: st_nxt.rdata = {10'h000, port_pin_s};
                pinctl_pkg::OFS_STATUS:
                begin
                    st_nxt.rdata[pinctl_pkg::STAT_NMI_BIT] = nmi_pin_s;
                    st_nxt.rdata[pinctl_pkg::STAT_PD_BIT] = st_r.pd_mode;
                    st_nxt.rdata[pinctl_pkg::STAT_RST_BIT] = st_r.rst_req;
                    st_nxt.rdata[pinctl_pkg::STAT_PDIGN_BIT] = st_r.pd_ign_seen;
                end
                pinctl_pkg::OFS_MEM_BUS_CTRL: st_nxt.rdata = {12'h000, st_r.waitstates};
                default: st_nxt.rdata = 16'h0000;
            endcase
        end

        // Pin drivers: compare output replaces the latch where alt is set
        drive_val = (st_r.port_alt & capcom_compare_out) | (~st_r.port_alt & st_r.port_data);
        st_nxt.pin_out = drive_val & ~st_r.port_od;
        st_nxt.pin_oe = st_r.port_dir & (~st_r.port_od | ~drive_val);

        // Inputs for capture channels 16-21 and fast interrupts
        st_nxt.cap_in = port_pin_s;
        st_nxt.irq7 = sel7 ? port_pin_s[2] : port_pin_s[0];
        st_nxt.irq6 = sel6 ? port_pin_s[3] : port_pin_s[1];
    end

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            st_r.port_data <= pinctl_pkg::PORT_DATA_RST;
            st_r.port_dir <= pinctl_pkg::PORT_DIR_RST;
            st_r.port_od <= pinctl_pkg::PORT_OD_RST;
            st_r.port_alt <= pinctl_pkg::PORT_ALT_RST;
            st_r.port_ctrl <= pinctl_pkg::PORT_CTRL_RST;
            st_r.waitstates <= pinctl_pkg::WS_RST;
            st_r.low_cnt <= 3'h0;
            st_r.rst_req <= 1'b0;
            st_r.nmi_prev <= 1'b1;
            st_r.nmi_trap <= 1'b0;
            st_r.pd_mode <= 1'b0;
            st_r.pd_ign <= 1'b0;
            st_r.pd_ign_seen <= 1'b0;
            st_r.pin_out <= 6'h00;
            st_r.pin_oe <= 6'h00;
            st_r.cap_in <= 6'h3F;
            st_r.irq7 <= 1'b1;
            st_r.irq6 <= 1'b1;
            st_r.rdata <= 16'h0000;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata = st_r.rdata;
    assign sys_reset_req = st_r.rst_req;
    assign nmi_trap_req = st_r.nmi_trap;
    assign power_down_mode = st_r.pd_mode;
    assign power_down_ignored = st_r.pd_ign;
    assign ninth_port_out = st_r.pin_out;
    assign ninth_port_oe = st_r.pin_oe;
    assign special_threshold = st_r.port_ctrl[pinctl_pkg::CTRL_THR_BIT];
    assign capcom_capture_in = st_r.cap_in;
    assign fast_ext_irq_seven_input = st_r.irq7;
    assign fast_ext_irq_six_input = st_r.irq6;
    assign flash_waitstate_field = st_r.waitstates;
endmodule

// ===== inc/pinctl_pkg.sv
// Constants and register map of the reset, NMI and ninth-port pin control block
package pinctl_pkg;
    // Register bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam int PORT_W = 6;
    localparam int WS_W = 4;

    // Register byte offsets
    localparam logic [7:0] OFS_PORT_DATA = 8'h00;
    localparam logic [7:0] OFS_PORT_DIR = 8'h04;
    localparam logic [7:0] OFS_PORT_OD = 8'h08;
    localparam logic [7:0] OFS_PORT_ALT = 8'h0C;
    localparam logic [7:0] OFS_PORT_CTRL = 8'h10;
    localparam logic [7:0] OFS_PORT_PINS = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    localparam logic [7:0] OFS_MEM_BUS_CTRL = 8'h1C;

    // Field positions in the port control register
    localparam int CTRL_THR_BIT = 0;
    localparam int CTRL_SEL7_BIT = 1;
    localparam int CTRL_SEL6_BIT = 2;

    // Field positions in the status register
    localparam int STAT_NMI_BIT = 0;
    localparam int STAT_PD_BIT = 1;
    localparam int STAT_RST_BIT = 2;
    localparam int STAT_PDIGN_BIT = 3;

    // Field position of the flash wait-state field
    localparam int WS_LSB = 0;

    // Reset values
    localparam logic [5:0] PORT_DATA_RST = 6'h00;
    localparam logic [5:0] PORT_DIR_RST = 6'h00;
    localparam logic [5:0] PORT_OD_RST = 6'h00;
    localparam logic [5:0] PORT_ALT_RST = 6'h00;
    localparam logic [2:0] PORT_CTRL_RST = 3'h0;
    localparam logic [3:0] WS_RST = 4'hF;

    // Timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int RST_REJECT_NS = 10;
    localparam int RST_PASS_NS = 100;
    localparam int RST_REJECT_CYC_RAW = (RST_REJECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RST_REJECT_CYC = (RST_REJECT_CYC_RAW < 1) ? 1 : RST_REJECT_CYC_RAW;
    localparam int RST_PASS_CYC_RAW = RST_PASS_NS / CLK_PERIOD_NS;
    localparam int RST_PASS_CYC = (RST_PASS_CYC_RAW < 1) ? 1 : RST_PASS_CYC_RAW;
    localparam int RST_FILT_CYC = (RST_PASS_CYC > RST_REJECT_CYC) ? RST_PASS_CYC : RST_REJECT_CYC + 1;
    localparam int RST_CNT_W = 3;
endpackage

// ===== core/pin_sync.sv
// Two-stage synchroniser for a group of asynchronous pin inputs
`timescale 1ns/1ps

module pin_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '1
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Asynchronous inputs and their synchronised copies
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    typedef struct packed {
        logic [W-1:0] stage1;
        logic [W-1:0] stage2;
    } sync_state_t;

    sync_state_t state_r;
    sync_state_t state_nxt;

    always_comb
    begin
        state_nxt = state_r;
        state_nxt.stage1 = async_in;
        state_nxt.stage2 = state_r.stage1;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            state_r.stage1 <= INIT;
            state_r.stage2 <= INIT;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    assign sync_out = state_r.stage2;
endmodule

// ===== verif/pinctl_sva.sv
// Assertion checker for the pin control block
`timescale 1ns/1ps
module pinctl_sva (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Pins and CPU side
    input wire logic reset_input_pin_n,
    input wire logic nmi_pin_n,
    input wire logic power_down_instruction,
    input wire logic sys_reset_req,
    input wire logic nmi_trap_req,
    input wire logic power_down_mode,
    input wire logic power_down_ignored
);
    logic [1:0] lo_r;
    logic [1:0] hi_r;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    // NMI runs restart at reset, as the synchroniser restarts at one
    always_ff @(posedge sys_clk)
    begin
        lo_r <= (!nrst || nmi_pin_n) ? 2'h0 : lo_r + {1'b0, lo_r != 2'h3};
        hi_r <= (!nrst || !nmi_pin_n) ? 2'h0 : hi_r + {1'b0, hi_r != 2'h3};
    end
    reset_enter_a: assert property ((!reset_input_pin_n)[*6] |-> sys_reset_req)
        else $error("reset pin low but no reset request");
    reset_leave_a: assert property (reset_input_pin_n[*5] |-> !sys_reset_req)
        else $error("reset request after pin release");
    spike_reject_a: assert property (reset_input_pin_n[*4] ##1 !reset_input_pin_n ##1 reset_input_pin_n
        |-> (!sys_reset_req)[*6])
        else $error("single sample reset spike passed");
    nmi_edge_a: assert property ($fell(nmi_pin_n) && hi_r == 2'h3 && reset_input_pin_n && !sys_reset_req
        |-> ##[2:5] nmi_trap_req)
        else $error("no trap request after NMI fall");
    nmi_pulse_a: assert property (nmi_trap_req |=> !nmi_trap_req)
        else $error("trap request longer than one cycle");
    nmi_sync_a: assert property ($fell(nmi_pin_n) |=> !nmi_trap_req)
        else $error("trap request before synchronisation");
    pd_enter_a: assert property (power_down_instruction && lo_r == 2'h3 && !power_down_mode && !sys_reset_req
        |=> power_down_mode)
        else $error("power-down not entered with NMI low");
    pd_ignore_a: assert property (power_down_instruction && hi_r == 2'h3 && !power_down_mode && !sys_reset_req
        |=> power_down_ignored && !power_down_mode)
        else $error("power-down not refused with NMI high");
    pd_hold_a: assert property (power_down_mode && !sys_reset_req |=> power_down_mode)
        else $error("power-down left without reset");
    cover property ($rose(sys_reset_req));
    cover property (nmi_trap_req);
    cover property (power_down_mode);
    cover property (power_down_ignored);
endmodule

// ===== verif/pin_board.sv
// Board model: reset circuit, NMI source and ninth-port wiring
`timescale 1ns/1ps
module pin_board (
    // Clock
    input wire logic sys_clk,
    // Pins
    output logic reset_input_pin_n,
    output logic nmi_pin_n,
    output logic [5:0] ninth_port_in,
    input wire logic [5:0] ninth_port_out,
    input wire logic [5:0] ninth_port_oe
);
    logic [5:0] ext_r;
    // Pull-ups hold reset and NMI released at start
    initial
    begin
        reset_input_pin_n = 1'b1;
        nmi_pin_n = 1'b1;
        ext_r = 6'h00;
    end
    // A released pin shows the external source
    assign ninth_port_in = (ninth_port_oe & ninth_port_out) | (~ninth_port_oe & ext_r);
    task automatic hold_reset(input int n);
        @(posedge sys_clk);
        reset_input_pin_n <= 1'b0;
        repeat (n) @(posedge sys_clk);
        reset_input_pin_n <= 1'b1;
    endtask
    task automatic set_pins(input logic nmi, input logic [5:0] ext);
        @(posedge sys_clk);
        nmi_pin_n <= nmi;
        ext_r <= ext;
    endtask
endmodule

// ===== verif/reset_nmi_port_pin_control_tb.sv
// Self-checking bench for the pin control block
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin n_fail++; \
$display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module reset_nmi_port_pin_control_tb;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic power_down_instruction = 1'b0;
    logic [5:0] capcom_compare_out = 6'h00;
    logic [15:0] reg_rdata;
    logic reset_input_pin_n, nmi_pin_n, sys_reset_req, nmi_trap_req, power_down_mode, power_down_ignored;
    logic special_threshold, irq7, irq6;
    logic [5:0] ninth_port_in, ninth_port_out, ninth_port_oe, capcom_capture_in;
    logic [3:0] flash_waitstate_field;
    int n_fail = 0;
    int samples_checked = 0;
    int k;
    always #25 sys_clk = ~sys_clk;
    pin_board pin_board_i (.sys_clk(sys_clk), .reset_input_pin_n(reset_input_pin_n), .nmi_pin_n(nmi_pin_n),
        .ninth_port_in(ninth_port_in), .ninth_port_out(ninth_port_out), .ninth_port_oe(ninth_port_oe));
    pin_control pin_control_i (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reset_input_pin_n(reset_input_pin_n),
        .nmi_pin_n(nmi_pin_n), .power_down_instruction(power_down_instruction), .sys_reset_req(sys_reset_req),
        .nmi_trap_req(nmi_trap_req), .power_down_mode(power_down_mode), .power_down_ignored(power_down_ignored),
        .ninth_port_in(ninth_port_in), .ninth_port_out(ninth_port_out), .ninth_port_oe(ninth_port_oe),
        .special_threshold(special_threshold), .capcom_compare_out(capcom_compare_out),
        .capcom_capture_in(capcom_capture_in), .fast_ext_irq_seven_input(irq7), .fast_ext_irq_six_input(irq6),
        .flash_waitstate_field(flash_waitstate_field));
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 `CHK(reg_rdata, e)
    endtask
    task automatic pd_pulse;
        @(posedge sys_clk);
        power_down_instruction <= 1'b1;
        @(posedge sys_clk);
        power_down_instruction <= 1'b0;
        #1;
    endtask
    task automatic give_verdict;
        $display("checks %0d errors %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        repeat (3000) @(posedge sys_clk);
        n_fail++;
        give_verdict;
    end
    initial
    begin
        repeat (4) @(posedge sys_clk);
        nrst <= 1'b1;
        tick(3);
        `CHK(flash_waitstate_field, 4'hF)
        `CHK(special_threshold, 1'b0)
        rd(8'h1C, 16'h000F);
        rd(8'hFE, 16'h0000);
        wr(8'h1C, 16'h0003);
        rd(8'h1C, 16'h0003);
        `CHK(flash_waitstate_field, 4'h3)
        wr(8'h04, 16'h003F);
        wr(8'h08, 16'h0030);
        wr(8'h00, 16'h0015);
        tick(2);
        `CHK(ninth_port_out, 6'h05)
        `CHK(ninth_port_oe, 6'h2F)
        wr(8'h08, 16'h0000);
        wr(8'h0C, 16'h003F);
        capcom_compare_out <= 6'h2A;
        tick(3);
        `CHK(ninth_port_out, 6'h2A)
        `CHK(ninth_port_oe, 6'h3F)
        wr(8'h04, 16'h0000);
        pin_board_i.set_pins(1'b1, 6'h09);
        tick(5);
        `CHK(ninth_port_oe, 6'h00)
        `CHK(capcom_capture_in, 6'h09)
        `CHK({irq7, irq6}, 2'h2)
        rd(8'h14, 16'h0009);
        wr(8'h10, 16'h0007);
        tick(3);
        `CHK({irq7, irq6}, 2'h1)
        `CHK(special_threshold, 1'b1)
        rd(8'h10, 16'h0007);
        pin_board_i.hold_reset(1);
        repeat (8)
        begin
            tick(1);
            `CHK(sys_reset_req, 1'b0)
        end
        pin_board_i.set_pins(1'b0, 6'h09);
        k = 0;
        while (nmi_trap_req !== 1'b1 && k < 8)
        begin
            tick(1);
            k++;
        end
        `CHK(nmi_trap_req, 1'b1)
        tick(1);
        `CHK(nmi_trap_req, 1'b0)
        pd_pulse;
        `CHK(power_down_mode, 1'b1)
        rd(8'h18, 16'h0002);
        pin_board_i.hold_reset(6);
        #1 `CHK(sys_reset_req, 1'b1)
        pin_board_i.set_pins(1'b1, 6'h09);
        tick(6);
        `CHK({sys_reset_req, power_down_mode}, 2'h0)
        pd_pulse;
        `CHK({power_down_ignored, power_down_mode}, 2'h2)
        // Sticky ignored flag shows once, then the status read has cleared it
        rd(8'h18, 16'h0009);
        rd(8'h18, 16'h0001);
        give_verdict;
    end
endmodule
bind pin_control pinctl_sva pinctl_sva_i (.sys_clk(sys_clk), .nrst(nrst), .reset_input_pin_n(reset_input_pin_n),
    .nmi_pin_n(nmi_pin_n), .power_down_instruction(power_down_instruction), .sys_reset_req(sys_reset_req),
    .nmi_trap_req(nmi_trap_req), .power_down_mode(power_down_mode), .power_down_ignored(power_down_ignored));
